// *** verilog/msd_pkg.sv ***
// constants and types shared by the memory space decoder
// assumes a single core clock domain and a synchronous reset
package msd_pkg;

  // program memory
  localparam int PC_W = 16;
  localparam logic [PC_W-1:0] PC_RESET = 16'h0000;
  localparam logic [PC_W-1:0] VEC_BASE = 16'h0003;
  localparam int VEC_SHIFT = 3;
  localparam int VEC_IDX_W = 4;
  localparam int FLASH_8K = 8192;
  localparam int FLASH_16K = 16384;

  // internal data memory
  localparam int IADDR_W = 8;
  localparam logic [IADDR_W-1:0] UPPER_BASE = 8'h80;
  localparam logic [IADDR_W-1:0] BITAREA_BASE = 8'h20;
  localparam logic [IADDR_W-1:0] BITADDR_SFR = 8'h80;
  localparam logic [IADDR_W-1:0] BIT_SFR_MASK = 8'hf8;
  localparam int BIT_SEL_W = 3;
  localparam int BIT_BYTE_W = 4;
  localparam int BANK_W = 2;
  localparam int REG_IDX_W = 3;
  localparam logic [BANK_W-1:0] BANK_RESET = 2'h0;

  // external data memory
  localparam int XADDR_W = 16;
  localparam int EXTERNAL_DATA_RAM_SMALL = 256;
  localparam int EXTERNAL_DATA_RAM_LARGE = 768;

  typedef enum logic [1:0] {
    MSD_XS_EXTERNAL_DATA_RAM = 2'b00,
    MSD_XS_EXTENDED_FUNCTION_SPACE = 2'b01,
    MSD_XS_DFLASH = 2'b11,
    MSD_XS_NONE = 2'b10
  } msd_xspace_t;

  // debug pin claim, gray along reset -> user and reset -> debug
  typedef enum logic [1:0] {
    MSD_CL_RESET = 2'b00,
    MSD_CL_DEBUG = 2'b01,
    MSD_CL_USER = 2'b10
  } msd_claim_t;

endpackage

// *** verilog/msd_bitdec.sv ***
// bit address to byte address and bit mask
// purely combinational; the caller registers the result
`timescale 1ns/1ps
module msd_bitdec
  import msd_pkg::*;
(
  input wire logic [msd_pkg::IADDR_W-1:0] bit_addr_i,
  output logic [msd_pkg::IADDR_W-1:0] byte_addr_o,
  output logic [msd_pkg::IADDR_W-1:0] mask_o,
  output logic sfr_o
);

  wire logic to_sfr;
  wire logic [BIT_SEL_W-1:0] bit_sel;
  wire logic [BIT_BYTE_W-1:0] ram_byte;

  assign to_sfr = (bit_addr_i >= BITADDR_SFR);
  assign bit_sel = bit_addr_i[BIT_SEL_W-1:0];
  assign ram_byte = bit_addr_i[BIT_SEL_W+BIT_BYTE_W-1:BIT_SEL_W];

  // sfr bits only land on bytes ending in 0 or 8
  assign byte_addr_o = to_sfr ? (bit_addr_i & BIT_SFR_MASK) // R15
                              : (BITAREA_BASE
                                 + IADDR_W'(ram_byte)); // R10
  assign mask_o = IADDR_W'(1) << bit_sel;
  assign sfr_o = to_sfr;

endmodule

// *** verilog/msd_decoder.sv ***
// memory space decoder: program counter, internal, external and
// data flash address selection, debug and reset pin claim at reset
// assumes the core presents one data request a cycle, synchronous
// to mclk_i, and answers are taken one cycle later from the outputs
//
// Overview of operation
// R01 - leaving reset, the first fetch address is zero
// R02 - each interrupt jumps to its own fixed vector; int 1 at 000B
// R03 - vector locations sit eight bytes apart
// R04 - program counter is 16 bits; only 8K or 16K flash exists
// R05 - internal data addresses are one byte, 256-byte space with stack
// R06 - 80 to FF: direct picks function space, indirect picks upper RAM
// R07 - upper RAM and function space share 80 to FF as separate stores
// R08 - upper RAM indirect only; lower RAM direct or indirect
// R09 - lowest 32 bytes are four banks of eight working registers
// R10 - 16 bytes above banks are bit-addressable, bits 00 to 7F
// R11 - external data addresses come from the data pointer pair
// R12 - external data RAM is 256 or 768 bytes
// R13 - extended function area is separate, 8-bit access only
// R14 - data flash read via pointer; erase and write through buffer
// R15 - function registers at addresses ending 0 or 8 are bit-addressable
// R16 - emulator seen on debug pins at reset claims them for debug
// R17 - debug pins are pulled-up inputs only while reset is active
// R18 - nonvolatile option picks reset input or port and serial clock
// R19 - bank n starts at address 8n; bank zero after reset
`timescale 1ns/1ps
module msd_decoder
  import msd_pkg::*;
#(
  parameter int FLASH_BYTES = FLASH_16K,
  parameter int EXTERNAL_DATA_RAM_BYTES = EXTERNAL_DATA_RAM_LARGE
) (
  input wire logic mclk_i,
  input wire logic srst_i,
  // instruction fetch
  input wire logic pc_inc_i,
  input wire logic pc_jump_i,
  input wire logic [msd_pkg::PC_W-1:0] pc_jump_addr_i,
  input wire logic irq_take_i,
  input wire logic [msd_pkg::VEC_IDX_W-1:0] irq_vec_idx_i,
  output logic [msd_pkg::PC_W-1:0] pc_o,
  output logic prog_hit_o,
  // register bank select, mirrored from the status word
  input wire logic bank_wr_i,
  input wire logic [msd_pkg::BANK_W-1:0] bank_i,
  output logic [msd_pkg::BANK_W-1:0] bank_o,
  // internal data access
  input wire logic d_req_i,
  input wire logic d_wr_i,
  input wire logic d_indirect_i,
  input wire logic d_bit_i,
  input wire logic d_wreg_i,
  input wire logic [msd_pkg::REG_IDX_W-1:0] d_wreg_idx_i,
  input wire logic [msd_pkg::IADDR_W-1:0] d_addr_i,
  output logic d_lower_sel_o,
  output logic d_upper_sel_o,
  output logic d_sfr_sel_o,
  output logic d_wr_o,
  output logic [msd_pkg::IADDR_W-1:0] d_addr_o,
  output logic [msd_pkg::IADDR_W-1:0] d_bit_mask_o,
  // external data access
  input wire logic x_req_i,
  input wire logic x_wr_i,
  input wire msd_pkg::msd_xspace_t x_space_i,
  input wire logic [7:0] dph_i,
  input wire logic [7:0] dpl_i,
  output logic x_ram_sel_o,
  output logic x_sfr_sel_o,
  output logic x_dflash_rd_o,
  output logic x_dflash_buf_wr_o,
  output logic x_wr_o,
  output logic x_err_o,
  output logic [msd_pkg::XADDR_W-1:0] x_addr_o,
  // pins and options
  input wire logic emu_attach_i,
  input wire logic cfg_reset_pin_i,
  input wire logic ext_reset_pin_n_i,
  output logic dbg_func_o,
  output logic dbg_pullup_o,
  output logic dbg_input_o,
  output logic reset_pin_mode_o,
  output logic port_sck_en_o,
  output logic ext_reset_req_o
);

  generate
    if (FLASH_BYTES != FLASH_8K && FLASH_BYTES != FLASH_16K) begin : g_fl
      $error("FLASH_BYTES must be 8192 or 16384");
    end
    if (EXTERNAL_DATA_RAM_BYTES != EXTERNAL_DATA_RAM_SMALL && EXTERNAL_DATA_RAM_BYTES != EXTERNAL_DATA_RAM_LARGE) begin : g_xr
      $error("EXTERNAL_DATA_RAM_BYTES must be 256 or 768");
    end
  endgenerate

  localparam logic [PC_W-1:0] FLASH_TOP = PC_W'(FLASH_BYTES);
  localparam logic [XADDR_W-1:0] EXTERNAL_DATA_RAM_TOP = XADDR_W'(EXTERNAL_DATA_RAM_BYTES);

  // ---------------- program counter ----------------
  logic [PC_W-1:0] pc_ff;
  logic prog_hit_ff;
  wire logic [PC_W-1:0] vec_addr;
  wire logic [PC_W-1:0] nxt_pc;

  assign vec_addr = VEC_BASE
                    + (PC_W'(irq_vec_idx_i) << VEC_SHIFT); // R02 R03
  // interrupt entry wins over a jump, a jump over sequential fetch
  assign nxt_pc = irq_take_i ? vec_addr :
                  pc_jump_i ? pc_jump_addr_i :
                  pc_inc_i ? PC_W'(pc_ff + 1'b1) : pc_ff; // R04

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      pc_ff <= PC_RESET; // R01
      prog_hit_ff <= 1'b1;
    end else begin
      pc_ff <= nxt_pc;
      prog_hit_ff <= (nxt_pc < FLASH_TOP); // R04
    end
  end

  assign pc_o = pc_ff;
  assign prog_hit_o = prog_hit_ff;

  // ---------------- register bank ----------------
  logic [BANK_W-1:0] bank_ff;

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      bank_ff <= BANK_RESET; // R19
    end else if (bank_wr_i) begin
      bank_ff <= bank_i; // R09
    end
  end

  assign bank_o = bank_ff;

  // ---------------- internal data decode ----------------
  wire logic [IADDR_W-1:0] bit_byte;
  wire logic [IADDR_W-1:0] bit_mask;
  wire logic bit_to_sfr;
  wire logic [IADDR_W-1:0] wreg_addr;
  wire logic [IADDR_W-1:0] eff_addr;
  wire logic eff_high;
  wire logic eff_indirect;
  wire logic nxt_lower;
  wire logic nxt_upper;
  wire logic nxt_sfr;

  msd_bitdec u_bitdec (
    .bit_addr_i(d_addr_i),
    .byte_addr_o(bit_byte),
    .mask_o(bit_mask),
    .sfr_o(bit_to_sfr)
  );

  // bank n occupies 8n .. 8n+7
  assign wreg_addr = IADDR_W'({bank_ff, d_wreg_idx_i}); // R09 R19
  assign eff_addr = d_wreg_i ? wreg_addr :
                    d_bit_i ? bit_byte : d_addr_i; // R05
  assign eff_high = (eff_addr >= UPPER_BASE);
  // bit operations are direct by nature, so never reach upper RAM
  assign eff_indirect = d_indirect_i & ~d_bit_i & ~d_wreg_i;
  assign nxt_lower = d_req_i & ~eff_high; // R08
  assign nxt_upper = d_req_i & eff_high & eff_indirect; // R06 R08
  assign nxt_sfr = d_req_i & eff_high & ~eff_indirect; // R06 R07

  logic d_lower_ff;
  logic d_upper_ff;
  logic d_sfr_ff;
  logic d_wr_ff;
  logic [IADDR_W-1:0] d_addr_ff;
  logic [IADDR_W-1:0] d_mask_ff;

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      d_lower_ff <= 1'b0;
      d_upper_ff <= 1'b0;
      d_sfr_ff <= 1'b0;
      d_wr_ff <= 1'b0;
      d_addr_ff <= '0;
      d_mask_ff <= '0;
    end else begin
      d_lower_ff <= nxt_lower;
      d_upper_ff <= nxt_upper;
      d_sfr_ff <= nxt_sfr;
      d_wr_ff <= d_req_i & d_wr_i;
      d_addr_ff <= eff_addr;
      d_mask_ff <= d_bit_i ? bit_mask : '0; // R10 R15
    end
  end

  assign d_lower_sel_o = d_lower_ff;
  assign d_upper_sel_o = d_upper_ff;
  assign d_sfr_sel_o = d_sfr_ff;
  assign d_wr_o = d_wr_ff;
  assign d_addr_o = d_addr_ff;
  assign d_bit_mask_o = d_mask_ff;

  // ---------------- external data decode ----------------
  wire logic [XADDR_W-1:0] data_pointer_pair;
  wire logic external_data_ram_in;
  wire logic nxt_x_ram;
  wire logic nxt_x_sfr;
  wire logic nxt_x_dfl_rd;
  wire logic nxt_x_dfl_buf;
  wire logic nxt_x_err;

  assign data_pointer_pair = {dph_i, dpl_i}; // R11
  assign external_data_ram_in = (data_pointer_pair < EXTERNAL_DATA_RAM_TOP);
  assign nxt_x_ram = x_req_i & (x_space_i == MSD_XS_EXTERNAL_DATA_RAM)
                     & external_data_ram_in; // R12
  assign nxt_x_sfr = x_req_i & (x_space_i == MSD_XS_EXTENDED_FUNCTION_SPACE); // R13
  assign nxt_x_dfl_rd = x_req_i & (x_space_i == MSD_XS_DFLASH)
                        & ~x_wr_i; // R14
  // stores never hit the flash array; they land in the page buffer
  assign nxt_x_dfl_buf = x_req_i & (x_space_i == MSD_XS_DFLASH)
                         & x_wr_i; // R14
  assign nxt_x_err = x_req_i & (((x_space_i == MSD_XS_EXTERNAL_DATA_RAM) & ~external_data_ram_in)
                     | (x_space_i == MSD_XS_NONE));

  logic x_ram_ff;
  logic x_sfr_ff;
  logic x_dfl_rd_ff;
  logic x_dfl_buf_ff;
  logic x_wr_ff;
  logic x_err_ff;
  logic [XADDR_W-1:0] x_addr_ff;

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      x_ram_ff <= 1'b0;
      x_sfr_ff <= 1'b0;
      x_dfl_rd_ff <= 1'b0;
      x_dfl_buf_ff <= 1'b0;
      x_wr_ff <= 1'b0;
      x_err_ff <= 1'b0;
      x_addr_ff <= '0;
    end else begin
      x_ram_ff <= nxt_x_ram;
      x_sfr_ff <= nxt_x_sfr;
      x_dfl_rd_ff <= nxt_x_dfl_rd;
      x_dfl_buf_ff <= nxt_x_dfl_buf;
      x_wr_ff <= (nxt_x_ram | nxt_x_sfr) & x_wr_i;
      x_err_ff <= nxt_x_err;
      x_addr_ff <= data_pointer_pair; // R11
    end
  end

  assign x_ram_sel_o = x_ram_ff;
  assign x_sfr_sel_o = x_sfr_ff;
  assign x_dflash_rd_o = x_dfl_rd_ff;
  assign x_dflash_buf_wr_o = x_dfl_buf_ff;
  assign x_wr_o = x_wr_ff;
  assign x_err_o = x_err_ff;
  assign x_addr_o = x_addr_ff;

  // ---------------- debug and reset pin claim ----------------
  msd_claim_t claim_ff;
  msd_claim_t nxt_claim;
  logic emu_seen_ff;
  logic rst_d_ff;
  logic pullup_ff;
  logic rst_mode_ff;
  logic ext_req_ff;
  logic dbg_func_ff;
  logic sck_en_ff;
  wire logic rst_cont;
  wire logic nxt_dbg_func;

  // emulator presence is sampled on clock edges while reset is held;
  // a fresh reset restarts the sample, so an unknown history is dropped
  assign rst_cont = srst_i & rst_d_ff;

  always_ff @(posedge mclk_i) begin
    rst_d_ff <= srst_i;
    if (rst_cont) begin
      emu_seen_ff <= emu_seen_ff | emu_attach_i; // R16
    end else if (srst_i) begin
      emu_seen_ff <= emu_attach_i; // R16
    end
  end

  always_comb begin
    nxt_claim = claim_ff;
    case (claim_ff)
      MSD_CL_RESET: begin
        nxt_claim = emu_seen_ff ? MSD_CL_DEBUG : MSD_CL_USER; // R16
      end
      MSD_CL_DEBUG: nxt_claim = MSD_CL_DEBUG;
      MSD_CL_USER: nxt_claim = MSD_CL_USER;
      default: nxt_claim = MSD_CL_RESET;
    endcase
  end

  assign nxt_dbg_func = (nxt_claim == MSD_CL_DEBUG); // R16

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      claim_ff <= MSD_CL_RESET;
      dbg_func_ff <= 1'b0;
      pullup_ff <= 1'b1; // R17
    end else begin
      claim_ff <= nxt_claim;
      dbg_func_ff <= nxt_dbg_func; // R16
      pullup_ff <= 1'b0; // R17
    end
  end

  // the option is latched while reset is held, so a flipping option
  // line cannot change the pin role during operation
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      rst_mode_ff <= cfg_reset_pin_i; // R18
      // own flop rather than an inverter, so the pin role output is clean
      sck_en_ff <= ~cfg_reset_pin_i; // R18
      ext_req_ff <= 1'b0;
    end else begin
      ext_req_ff <= rst_mode_ff & ~ext_reset_pin_n_i; // R18
    end
  end

  assign dbg_func_o = dbg_func_ff;
  assign dbg_pullup_o = pullup_ff;
  assign dbg_input_o = pullup_ff;
  assign reset_pin_mode_o = rst_mode_ff;
  assign port_sck_en_o = sck_en_ff;
  assign ext_reset_req_o = ext_req_ff;

endmodule

// *** dv/msd_checker.sv ***
// assertions on the memory space decoder ports
// assumes binding into every msd_decoder, one clock domain
`timescale 1ns/1ps
module msd_checker
  import msd_pkg::*;
(
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic irq_take_i,
  input wire logic [msd_pkg::VEC_IDX_W-1:0] irq_vec_idx_i,
  input wire logic [msd_pkg::PC_W-1:0] pc_o,
  input wire logic [msd_pkg::BANK_W-1:0] bank_o,
  input wire logic d_req_i,
  input wire logic d_indirect_i,
  input wire logic d_bit_i,
  input wire logic d_wreg_i,
  input wire logic [msd_pkg::REG_IDX_W-1:0] d_wreg_idx_i,
  input wire logic [msd_pkg::IADDR_W-1:0] d_addr_i,
  input wire logic d_lower_sel_o,
  input wire logic d_upper_sel_o,
  input wire logic d_sfr_sel_o,
  input wire logic [msd_pkg::IADDR_W-1:0] d_addr_o,
  input wire logic [msd_pkg::IADDR_W-1:0] d_bit_mask_o,
  input wire logic x_req_i,
  input wire logic x_wr_i,
  input wire msd_pkg::msd_xspace_t x_space_i,
  input wire logic [7:0] dph_i,
  input wire logic [7:0] dpl_i,
  input wire logic x_wr_o,
  input wire logic x_dflash_buf_wr_o,
  input wire logic [msd_pkg::XADDR_W-1:0] x_addr_o,
  input wire logic dbg_pullup_o,
  input wire logic dbg_input_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (srst_i);
  property p_first;
    $fell(srst_i) |-> pc_o == PC_RESET && bank_o == BANK_RESET;
  endproperty
  a_first: assert property (p_first) else $error("start state");
  property p_vec;
    irq_take_i |=> pc_o == 16'h0003 + {$past(irq_vec_idx_i), 3'h0};
  endproperty
  a_vec: assert property (p_vec) else $error("vector");
  property p_upper;
    d_req_i && d_indirect_i && !d_bit_i && !d_wreg_i && d_addr_i[7]
      |=> d_upper_sel_o && !d_sfr_sel_o;
  endproperty
  a_upper: assert property (p_upper) else $error("upper ram");
  property p_sfr;
    d_req_i && !d_indirect_i && !d_wreg_i && d_addr_i[7] |=> d_sfr_sel_o;
  endproperty
  a_sfr: assert property (p_sfr) else $error("function space");
  property p_lower;
    d_req_i && !d_bit_i && !d_wreg_i && !d_addr_i[7]
      |=> d_lower_sel_o && d_addr_o == $past(d_addr_i);
  endproperty
  a_lower: assert property (p_lower) else $error("lower ram");
  property p_mask;
    d_req_i && d_bit_i && !d_wreg_i
      |=> d_bit_mask_o == 8'h01 << $past(d_addr_i[2:0]);
  endproperty
  a_mask: assert property (p_mask) else $error("bit mask");
  property p_wreg;
    d_req_i && d_wreg_i |=> d_lower_sel_o
      && d_addr_o == {3'h0, $past(bank_o), $past(d_wreg_idx_i)};
  endproperty
  a_wreg: assert property (p_wreg) else $error("working reg");
  property p_xaddr;
    x_req_i |=> x_addr_o == {$past(dph_i), $past(dpl_i)};
  endproperty
  a_xaddr: assert property (p_xaddr) else $error("pointer addr");
  property p_dflash;
    x_req_i && x_wr_i && x_space_i == MSD_XS_DFLASH
      |=> x_dflash_buf_wr_o && !x_wr_o;
  endproperty
  a_dflash: assert property (p_dflash) else $error("flash write");
  property p_pull;
    !$past(srst_i) |-> !dbg_pullup_o && !dbg_input_o;
  endproperty
  a_pull: assert property (p_pull) else $error("pull-up held");
  c_vec: cover property (irq_take_i && irq_vec_idx_i == 4'h1);
  c_upper: cover property (d_upper_sel_o);
  c_dflash: cover property (x_dflash_buf_wr_o);
endmodule
bind msd_decoder msd_checker i_msd_checker (.*);

// *** dv/msd_core_model.sv ***
// core side model issuing internal data requests
// assumes calls are made one after another from one process
`timescale 1ns/1ps
module msd_core_model (
  input wire logic mclk_i,
  output logic d_req_o,
  output logic d_wr_o,
  output logic d_indirect_o,
  output logic d_bit_o,
  output logic d_wreg_o,
  output logic [2:0] d_wreg_idx_o,
  output logic [7:0] d_addr_o
);
  initial begin
    {d_req_o, d_wr_o, d_indirect_o, d_bit_o, d_wreg_o} = 5'h00;
    {d_wreg_idx_o, d_addr_o} = 11'h0;
  end
  // back to back calls keep the request up
  // a lone request must be followed by idle, or it is taken again
  task automatic acc(logic r, i, b, w, logic [2:0] x, logic [7:0] a);
    @(posedge mclk_i);
    d_req_o <= 1'b1;
    {d_wr_o, d_indirect_o, d_bit_o, d_wreg_o} <= {r, i, b, w};
    {d_wreg_idx_o, d_addr_o} <= {x, a};
  endtask
  // released address must not look valid
  task automatic idle;
    @(posedge mclk_i);
    d_req_o <= 1'b0;
    d_wr_o <= ~d_wr_o;
    d_addr_o <= ~d_addr_o;
  endtask
endmodule

// *** dv/msd_decoder_bench.sv ***
// self-checking bench for the memory space decoder
// assumes msd_checker is bound from its own file
`timescale 1ns/1ps
module msd_decoder_bench;
  import msd_pkg::*;
  logic mclk_i = 1'b0, srst_i = 1'b1, pc_inc_i = 1'b0, pc_jump_i = 1'b0;
  logic irq_take_i = 1'b0, bank_wr_i = 1'b0, d_wr_i;
  logic x_req_i = 1'b0, x_wr_i = 1'b0, emu_attach_i = 1'b0;
  logic cfg_reset_pin_i = 1'b0, ext_reset_pin_n_i = 1'b1;
  logic [15:0] pc_jump_addr_i = 16'h0, pc_o, x_addr_o, r = 16'h0013;
  logic [3:0] irq_vec_idx_i = 4'h0;
  logic [1:0] bank_i = 2'h0, bank_o;
  logic [7:0] dph_i = 8'h0, dpl_i = 8'h0, d_addr_i, d_addr_o, d_bit_mask_o;
  logic [2:0] d_wreg_idx_i;
  logic d_req_i, d_indirect_i, d_bit_i, d_wreg_i, prog_hit_o, d_wr_o;
  logic d_lower_sel_o, d_upper_sel_o, d_sfr_sel_o, x_ram_sel_o, x_wr_o;
  logic x_sfr_sel_o, x_dflash_rd_o, x_dflash_buf_wr_o, x_err_o;
  logic dbg_func_o, dbg_pullup_o, dbg_input_o, reset_pin_mode_o;
  logic port_sck_en_o, ext_reset_req_o;
  msd_xspace_t x_space_i = MSD_XS_NONE;
  logic [19:0] expq[$];
  int fails = 0, checks = 0;
  msd_decoder i_msd_decoder (.*);
  msd_core_model i_msd_core_model (.mclk_i, .d_req_o(d_req_i),
    .d_wr_o(d_wr_i),
    .d_indirect_o(d_indirect_i), .d_bit_o(d_bit_i), .d_wreg_o(d_wreg_i),
    .d_wreg_idx_o(d_wreg_idx_i), .d_addr_o(d_addr_i));
  initial forever #4 mclk_i = ~mclk_i;
  task automatic finish_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(string n, logic [31:0] s, e);
    checks++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  function automatic logic [15:0] nxt(logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // {lower, upper, sfr, byte address, bit mask}
  function automatic logic [18:0] dexp(logic i, b, w, logic [2:0] x,
    logic [7:0] a, logic [1:0] bk);
    if (w) return {3'b100, 3'h0, bk, x, 8'h00};
    if (b) return {!a[7], 1'b0, a[7], a[7] ? a & 8'hf8 : 8'h20 + a[6:3],
      8'h01 << a[2:0]};
    return {!a[7], a[7] & i, a[7] & !i, a, 8'h00};
  endfunction
  // expected bank is the one the bench wrote, not the design's copy
  task automatic dreq(logic i, b, w, logic [2:0] x, logic [7:0] a);
    logic wr;
    wr = a[0] ^ x[0];
    expq.push_back({wr, dexp(i, b, w, x, a, bank_i)});
    i_msd_core_model.acc(wr, i, b, w, x, a);
  endtask
  always @(posedge mclk_i) begin
    #1;
    if ((d_lower_sel_o | d_upper_sel_o | d_sfr_sel_o) === 1'b1) begin
      if (expq.size() == 0) chk("spare", 1, 0);
      else chk("data", {d_wr_o, d_lower_sel_o, d_upper_sel_o, d_sfr_sel_o,
        d_addr_o, d_bit_mask_o}, expq.pop_front());
    end
  end
  // ext bits: ram, sfr, flash read, buffer write, write, error
  task automatic xreq(msd_xspace_t s, logic w, logic [15:0] p, logic [5:0] e);
    @(posedge mclk_i);
    {x_req_i, x_space_i, x_wr_i, dph_i, dpl_i} <= {1'b1, s, w, p};
    @(posedge mclk_i);
    {x_req_i, dph_i, dpl_i} <= {1'b0, ~p};
    #1 chk("ext", {x_ram_sel_o, x_sfr_sel_o, x_dflash_rd_o,
      x_dflash_buf_wr_o, x_wr_o, x_err_o, x_addr_o}, {e, p});
  endtask
  initial begin
    #200us;
    fails++;
    finish_test;
  end
  initial begin
    repeat (2) @(posedge mclk_i);
    #1 chk("in reset", {dbg_pullup_o, dbg_input_o, pc_o}, 18'h30000);
    @(posedge mclk_i);
    srst_i <= 1'b0;
    @(posedge mclk_i);
    #1 chk("released", {dbg_func_o, port_sck_en_o, pc_o}, 18'h10000);
    for (int v = 0; v < 16; v++) begin
      @(posedge mclk_i);
      {irq_take_i, pc_inc_i, irq_vec_idx_i} <= {2'b11, v[3:0]};
      @(posedge mclk_i);
      {irq_take_i, pc_inc_i} <= 2'b00;
      #1 chk("vector", pc_o, 16'h0003 + v * 8);
    end
    @(posedge mclk_i);
    {pc_jump_i, pc_jump_addr_i} <= {1'b1, 16'h3fff};
    @(posedge mclk_i);
    {pc_jump_i, pc_inc_i} <= 2'b01;
    #1 chk("last", {prog_hit_o, pc_o}, 17'h13fff);
    @(posedge mclk_i);
    pc_inc_i <= 1'b0;
    #1 chk("past end", {prog_hit_o, pc_o}, 17'h04000);
    for (int k = 0; k < 4; k++) begin
      @(posedge mclk_i);
      {bank_wr_i, bank_i} <= {1'b1, k[1:0]};
      @(posedge mclk_i);
      bank_wr_i <= 1'b0;
      @(posedge mclk_i);
      #1 chk("bank", bank_o, k);
      dreq(1'b0, 1'b0, 1'b1, 3'h7, 8'h55);
      i_msd_core_model.idle;
    end
    dreq(1'b1, 1'b0, 1'b0, 3'h0, 8'h80);
    dreq(1'b0, 1'b0, 1'b0, 3'h0, 8'h80);
    dreq(1'b1, 1'b0, 1'b0, 3'h0, 8'h7f);
    dreq(1'b0, 1'b1, 1'b0, 3'h0, 8'h13);
    dreq(1'b1, 1'b1, 1'b0, 3'h0, 8'h8f);
    for (int n = 0; n < 80; n++) begin
      r = nxt(r);
      dreq(r[8], r[9] & r[10] & !r[11], r[11] & r[12], r[15:13], r[7:0]);
    end
    i_msd_core_model.idle;
    repeat (3) @(posedge mclk_i);
    chk("drained", expq.size(), 0);
    xreq(MSD_XS_EXTERNAL_DATA_RAM, 1'b1, 16'h02ff, 6'b100010);
    xreq(MSD_XS_EXTERNAL_DATA_RAM, 1'b0, 16'h0300, 6'b000001);
    xreq(MSD_XS_EXTENDED_FUNCTION_SPACE, 1'b1, 16'h1234, 6'b010010);
    xreq(MSD_XS_DFLASH, 1'b0, 16'h0040, 6'b001000);
    xreq(MSD_XS_DFLASH, 1'b1, 16'h0041, 6'b000100);
    xreq(MSD_XS_NONE, 1'b0, 16'h0000, 6'b000001);
    @(posedge mclk_i);
    {srst_i, emu_attach_i, cfg_reset_pin_i} <= 3'b111;
    @(posedge mclk_i);
    emu_attach_i <= 1'b0;
    @(posedge mclk_i);
    {srst_i, ext_reset_pin_n_i} <= 2'b00;
    repeat (2) @(posedge mclk_i);
    #1 chk("pins", {dbg_func_o, reset_pin_mode_o, port_sck_en_o,
      ext_reset_req_o, dbg_pullup_o}, 5'b11010);
    finish_test;
  end
endmodule
